// File: lpbc_defines.svh
// register indices, field positions, reset values and timing counts
// assumes: included by bare name, 10 MHz reference clock
`ifndef LPBC_DEFINES_SVH
`define LPBC_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LPBC_IDX_OTYPE     8'h71
`define LPBC_IDX_LINK      8'h72
`define LPBC_IDX_POL       8'h73
`define LPBC_IDX_DRIVE     8'h74
`define LPBC_IDX_BEHAV     8'h81
`define LPBC_IDX_MIN_DUTY  8'h90
`define LPBC_IDX_MAX_DUTY  8'h91
`define LPBC_IDX_PERIOD    8'h92
`define LPBC_IDX_PULSES    8'h93
`define LPBC_IDX_STATUS    8'h94

// ----------------------------------------------------------------
// field masks and reset values
// ----------------------------------------------------------------
`define LPBC_MASK_TWO      8'h03
`define LPBC_MASK_BEHAV    8'h0F
`define LPBC_MASK_PERIOD   8'h7F
`define LPBC_RST_ZERO      8'h00
`define LPBC_RST_MAX_DUTY  8'hFF
`define LPBC_RST_PERIOD    8'h04
`define LPBC_RST_PULSES    8'h01

// ----------------------------------------------------------------
// timing: one period lsb spans 32 ms, one breath is 510 duty steps
// ----------------------------------------------------------------
`define LPBC_CLK_KHZ        10000
`define LPBC_PERIOD_LSB_MS  32
`define LPBC_BREATH_STEPS   510
`define LPBC_STEP_CYCLES    ((`LPBC_PERIOD_LSB_MS * `LPBC_CLK_KHZ) / `LPBC_BREATH_STEPS)

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define LPBC_RESP_OKAY     2'h0
`define LPBC_RESP_SLVERR   2'h2

`endif

// File: lpbc_pkg.sv
// types shared by the lamp polarity and behavior controller
// assumes: constants come from lpbc_defines.svh
package lpbc_pkg;

    // behavior sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DIRECT,
        ST_BREATHE,
        ST_PULSE
    } lpbc_state_t;

    // per-lamp configuration slice
    typedef struct packed {
        logic       polarity;
        logic       sw_drive;
        logic       link;
        logic       output_type;
        logic [1:0] behavior;
    } lpbc_lamp_cfg_t;

endpackage : lpbc_pkg

// File: lpbc_top.sv
// lamp polarity / behavior controller with an axi4-lite register slave
// assumes: one 10 MHz clock, touch inputs asynchronous, pins resolved outside
`timescale 1ns/1ps
`include "lpbc_defines.svh"

// Functional notes
// RULE1 - polarity 0 inverts: active drive is low, duty is fraction of time low
// RULE2 - polarity 1 non-inverted: active is high or float, duty is time high
// RULE3 - duty values are applied regardless of polarity
// RULE4 - each breath ramps from minimum duty to maximum and back to minimum
// RULE5 - without touch or with drive bit clear, lamp runs at minimum duty
// RULE6 - linked lamp treats a touch exactly like drive bit set
// RULE7 - linked lamps follow touch; unlinked lamps follow the drive bit
// RULE8 - drive bits: lamp two bit 1, lamp one bit 0; 1 actuates
// RULE9 - behavior fields: lamp two bits 3..2, lamp one bits 1..0
// RULE10 - linked lamp starts behavior on start trigger, ends on stop trigger
// RULE11 - unlinked lamp: setting drive bit is touch, clearing is release
// RULE12 - non-actuated pin: high when inverted, low when non-inverted
// RULE13 - breathing lamp finishes its current breath before behavior change
// RULE14 - single pulse starts on set; bit ignored until pulses finish
// RULE15 - source switch follows new source at once; inactive acts as release
// RULE16 - period change while actuated: zero drive, restart, keep pulse count; code does this only in breathe or pulse state while the command is held
// RULE17 - non-inverted lamp brightness is inverse of duty settings
// RULE18 - behavior 00 direct, 01 single pulse, 10 breathe then pulse, 11 breathe
// RULE19 - output type 0 open drain, 1 push pull
// RULE20 - link bit 1 makes lamp respond to its paired touch input
// RULE21 - duty is produced by a free counter compared with current duty
// RULE22 - unused register bits ignore writes and read as zero
module lpbc_top #(
    parameter int STEP_CYCLES = `LPBC_STEP_CYCLES
) (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // axi4-lite write address
    input  wire logic [11:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    // axi4-lite write data
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // axi4-lite read address
    input  wire logic [11:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    // axi4-lite read data
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // touch detect inputs, bit 1 is touch_input_two
    input  wire logic [1:0]  TOUCH_IN,
    // lamp pins, oe low while driving
    output logic [1:0]       LAMP_OUT,
    output logic [1:0]       LAMP_OE_N
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [1:0] lamp_output_type;
    logic [1:0] sensor_lamp_link;
    logic [1:0] lamp_polarity_select;
    logic [1:0] lamp_software_drive;
    logic [3:0] lamp_behavior_select;
    logic [7:0] min_duty;
    logic [7:0] max_duty;
    logic [6:0] breathe_period;
    logic [7:0] pulse_count;
    logic [6:0] period_seen;
    logic       period_changed;
    logic [1:0] lamp_actuated;
    logic [1:0] lamp_breathing;

    // bus slave state
    logic [11:0] aw_addr;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        aw_have;
    logic        w_have;
    logic        do_write;

    // address hit test shared by the read and write paths
    function automatic logic addr_is(input logic [11:0] addr, input logic [7:0] idx);
        addr_is = (addr[1:0] == 2'h0) && (addr[11:2] == {2'h0, idx});
    endfunction : addr_is

    // known register test
    function automatic logic addr_known(input logic [11:0] addr);
        addr_known = addr_is(addr, `LPBC_IDX_OTYPE)    || addr_is(addr, `LPBC_IDX_LINK)
                  || addr_is(addr, `LPBC_IDX_POL)      || addr_is(addr, `LPBC_IDX_DRIVE)
                  || addr_is(addr, `LPBC_IDX_BEHAV)    || addr_is(addr, `LPBC_IDX_MIN_DUTY)
                  || addr_is(addr, `LPBC_IDX_MAX_DUTY) || addr_is(addr, `LPBC_IDX_PERIOD)
                  || addr_is(addr, `LPBC_IDX_PULSES)   || addr_is(addr, `LPBC_IDX_STATUS);
    endfunction : addr_known

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    assign do_write = aw_have && w_have && !S_AXI_BVALID;

    // address and data taken in either order, response after both
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            aw_addr       <= 12'h000;
            w_data        <= 8'h00;
            w_lane0       <= 1'b0;
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `LPBC_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_addr       <= S_AXI_AWADDR;
                aw_have       <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_data       <= S_AXI_WDATA[7:0];
                w_lane0      <= S_AXI_WSTRB[0];
                w_have       <= 1'b1;
                S_AXI_WREADY <= 1'b0;
            end
            if (do_write) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= addr_known(aw_addr) ? `LPBC_RESP_OKAY : `LPBC_RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    // register writes, unused bits dropped
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            lamp_output_type     <= 2'h0;
            sensor_lamp_link     <= 2'h0;
            lamp_polarity_select <= 2'h0;
            lamp_software_drive  <= 2'h0;
            lamp_behavior_select <= 4'h0;
            min_duty             <= `LPBC_RST_ZERO;
            max_duty             <= `LPBC_RST_MAX_DUTY;
            breathe_period       <= 7'(`LPBC_RST_PERIOD);
            pulse_count          <= `LPBC_RST_PULSES;
        end else if (do_write && w_lane0) begin
            if (addr_is(aw_addr, `LPBC_IDX_OTYPE))
                lamp_output_type <= w_data[1:0];          // RULE22
            if (addr_is(aw_addr, `LPBC_IDX_LINK))
                sensor_lamp_link <= w_data[1:0];
            if (addr_is(aw_addr, `LPBC_IDX_POL))
                lamp_polarity_select <= w_data[1:0];      // RULE22
            if (addr_is(aw_addr, `LPBC_IDX_DRIVE))
                lamp_software_drive <= w_data[1:0];       // RULE8
            if (addr_is(aw_addr, `LPBC_IDX_BEHAV))
                lamp_behavior_select <= w_data[3:0];      // RULE9
            if (addr_is(aw_addr, `LPBC_IDX_MIN_DUTY))
                min_duty <= w_data;
            if (addr_is(aw_addr, `LPBC_IDX_MAX_DUTY))
                max_duty <= w_data;
            if (addr_is(aw_addr, `LPBC_IDX_PERIOD))
                breathe_period <= w_data[6:0];
            if (addr_is(aw_addr, `LPBC_IDX_PULSES))
                pulse_count <= w_data;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= `LPBC_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RRESP   <= addr_known(S_AXI_ARADDR) ? `LPBC_RESP_OKAY : `LPBC_RESP_SLVERR;
            S_AXI_RDATA   <= 32'h0000_0000;
            if (addr_is(S_AXI_ARADDR, `LPBC_IDX_OTYPE))
                S_AXI_RDATA[1:0] <= lamp_output_type;
            if (addr_is(S_AXI_ARADDR, `LPBC_IDX_LINK))
                S_AXI_RDATA[1:0] <= sensor_lamp_link;
            if (addr_is(S_AXI_ARADDR, `LPBC_IDX_POL))
                S_AXI_RDATA[1:0] <= lamp_polarity_select;   // RULE22
            if (addr_is(S_AXI_ARADDR, `LPBC_IDX_DRIVE))
                S_AXI_RDATA[1:0] <= lamp_software_drive;    // RULE22
            if (addr_is(S_AXI_ARADDR, `LPBC_IDX_BEHAV))
                S_AXI_RDATA[3:0] <= lamp_behavior_select;   // RULE22
            if (addr_is(S_AXI_ARADDR, `LPBC_IDX_MIN_DUTY))
                S_AXI_RDATA[7:0] <= min_duty;
            if (addr_is(S_AXI_ARADDR, `LPBC_IDX_MAX_DUTY))
                S_AXI_RDATA[7:0] <= max_duty;
            if (addr_is(S_AXI_ARADDR, `LPBC_IDX_PERIOD))
                S_AXI_RDATA[6:0] <= breathe_period;
            if (addr_is(S_AXI_ARADDR, `LPBC_IDX_PULSES))
                S_AXI_RDATA[7:0] <= pulse_count;
            if (addr_is(S_AXI_ARADDR, `LPBC_IDX_STATUS))
                S_AXI_RDATA[3:0] <= {lamp_breathing, lamp_actuated};
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // shared timing: touch sync, pwm counter, step prescaler
    // ----------------------------------------------------------------
    logic [1:0]  touch_meta;
    logic [1:0]  touch_sync;
    logic [7:0]  pwm_cnt;
    logic [16:0] pre_cnt;
    logic        base_tick;

    // two-stage synchroniser on the touch pins
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            touch_meta <= 2'h0;
            touch_sync <= 2'h0;
        end else begin
            touch_meta <= TOUCH_IN;
            touch_sync <= touch_meta;
        end
    end

    // free pwm counter and duty step prescaler
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pwm_cnt   <= 8'h00;
            pre_cnt   <= 17'h00000;
            base_tick <= 1'b0;
        end else begin
            pwm_cnt   <= pwm_cnt + 8'h01;                   // RULE21
            base_tick <= (pre_cnt == 17'(STEP_CYCLES - 1));
            pre_cnt   <= (pre_cnt == 17'(STEP_CYCLES - 1)) ? 17'h00000 : pre_cnt + 17'h00001;
        end
    end

    // period change detect for breath restart
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            period_seen    <= 7'(`LPBC_RST_PERIOD);
            period_changed <= 1'b0;
        end else begin
            period_seen    <= breathe_period;
            period_changed <= (period_seen != breathe_period);
        end
    end

    // ----------------------------------------------------------------
    // per-lamp behavior sequencer and pin driver
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_lamp
        lpbc_pkg::lpbc_lamp_cfg_t cfg;
        lpbc_pkg::lpbc_state_t    state;
        logic [1:0] mode;
        logic [7:0] duty;
        logic [7:0] pulses_left;
        logic [6:0] step_cnt;
        logic       ramp_up;
        logic       stop_pend;
        logic       rearm;
        logic       cmd;
        logic       cmd_q;
        logic       step;
        logic       breath_end;
        logic       active_phase;
        logic       pin_level;

        assign cfg = '{polarity:    lamp_polarity_select[g],
                       sw_drive:    lamp_software_drive[g],
                       link:        sensor_lamp_link[g],
                       output_type: lamp_output_type[g],
                       behavior:    lamp_behavior_select[2*g+1:2*g]};

        // command source: touch when linked, drive bit otherwise
        assign cmd = cfg.link ? touch_sync[g] : cfg.sw_drive;   // RULE6 RULE7 RULE11 RULE15 RULE20
        assign step = base_tick && (step_cnt == 7'h00);
        assign breath_end = step && !ramp_up && (duty <= min_duty);

        // step divider per lamp, one lsb of period per duty step
        always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
                step_cnt <= 7'h00;
            end else if (period_changed) begin
                step_cnt <= 7'h00;
            end else if (base_tick) begin
                step_cnt <= (step_cnt == 7'h00) ?
                    ((breathe_period == 7'h00) ? 7'h00 : breathe_period - 7'h01) :
                    step_cnt - 7'h01;
            end
        end

        // behavior state machine
        always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
                state       <= lpbc_pkg::ST_IDLE;
                mode        <= 2'h0;
                duty        <= 8'h00;
                pulses_left <= 8'h00;
                ramp_up     <= 1'b1;
                stop_pend   <= 1'b0;
                rearm       <= 1'b0;
                cmd_q       <= 1'b0;
            end else begin
                cmd_q <= cmd;
                case (state)
                    lpbc_pkg::ST_IDLE: begin
                        duty    <= min_duty;                          // RULE5
                        ramp_up <= 1'b1;
                        if (cmd && (!cmd_q || rearm)) begin           // RULE10 RULE11
                            rearm     <= 1'b0;
                            stop_pend <= 1'b0;
                            mode      <= cfg.behavior;
                            case (cfg.behavior)                       // RULE18
                                2'h0: state <= lpbc_pkg::ST_DIRECT;
                                2'h1: begin
                                    state       <= lpbc_pkg::ST_PULSE;
                                    pulses_left <= pulse_count;
                                end
                                default: state <= lpbc_pkg::ST_BREATHE;
                            endcase
                        end else if (!cmd) begin
                            rearm <= 1'b0;
                        end
                    end
                    lpbc_pkg::ST_DIRECT: begin
                        duty <= max_duty;
                        if (!cmd) begin
                            state <= lpbc_pkg::ST_IDLE;               // RULE10 RULE15
                        end else if (cfg.behavior != mode) begin
                            state <= lpbc_pkg::ST_IDLE;
                            rearm <= 1'b1;
                        end
                    end
                    lpbc_pkg::ST_BREATHE, lpbc_pkg::ST_PULSE: begin
                        if (state == lpbc_pkg::ST_BREATHE && !cmd)
                            stop_pend <= 1'b1;
                        if (period_changed && cmd_q) begin
                            duty    <= 8'h00;                         // RULE16
                            ramp_up <= 1'b1;
                        end else if (breath_end) begin
                            ramp_up <= 1'b1;                          // RULE4
                            if (state == lpbc_pkg::ST_PULSE) begin
                                // pulse run ignores the command bit
                                if (pulses_left <= 8'h01) begin       // RULE14
                                    state       <= lpbc_pkg::ST_IDLE;
                                    pulses_left <= 8'h00;
                                end else begin
                                    pulses_left <= pulses_left - 8'h01;
                                end
                            end else if (stop_pend || !cmd) begin
                                stop_pend <= 1'b0;
                                if (mode == 2'h2) begin
                                    state       <= lpbc_pkg::ST_PULSE;
                                    pulses_left <= pulse_count;
                                end else begin
                                    state <= lpbc_pkg::ST_IDLE;
                                end
                            end else if (cfg.behavior != mode) begin
                                state <= lpbc_pkg::ST_IDLE;           // RULE13
                                rearm <= 1'b1;
                            end
                        end else if (step) begin
                            if (ramp_up) begin
                                if (duty >= max_duty)
                                    ramp_up <= 1'b0;
                                else
                                    duty <= duty + 8'h01;             // RULE4
                            end else begin
                                duty <= duty - 8'h01;
                            end
                        end
                    end
                    default: state <= lpbc_pkg::ST_IDLE;
                endcase
            end
        end

        // duty compare and polarity mapping
        assign active_phase = (pwm_cnt < duty);                       // RULE21 RULE3
        assign pin_level = cfg.polarity ? active_phase : !active_phase; // RULE1 RULE2 RULE12 RULE17

        // pin driver: push pull always drives, open drain floats the high level
        always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
                LAMP_OUT[g]  <= 1'b0;
                LAMP_OE_N[g] <= 1'b1;
            end else if (cfg.output_type) begin
                LAMP_OUT[g]  <= pin_level;                            // RULE19
                LAMP_OE_N[g] <= 1'b0;
            end else begin
                LAMP_OUT[g]  <= 1'b0;                                 // RULE19
                LAMP_OE_N[g] <= pin_level;
            end
        end

        // status view of the sequencer
        always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
                lamp_actuated[g]  <= 1'b0;
                lamp_breathing[g] <= 1'b0;
            end else begin
                lamp_actuated[g]  <= (state != lpbc_pkg::ST_IDLE);
                lamp_breathing[g] <= (state == lpbc_pkg::ST_BREATHE) ||
                                     (state == lpbc_pkg::ST_PULSE);
            end
        end
    end

endmodule : lpbc_top

// File: lpbc_lamp_load.sv
// far-side lamp load: pull-up on each lamp pin
// assumes: enable low while the design drives the pin
`timescale 1ns/1ps
module lpbc_lamp_load (
    // pin drive from the design
    input  wire logic [1:0] lamp_out,
    input  wire logic [1:0] lamp_oe_n,
    // resolved pin level
    output logic      [1:0] pin_level
);
    // a released pin is pulled high
    assign pin_level = (~lamp_oe_n & lamp_out) | lamp_oe_n;
endmodule : lpbc_lamp_load

// File: lpbc_monitor.sv
// checker: bus handshakes and lamp pins of lpbc_top
// assumes: bound into lpbc_top, one clock domain
`timescale 1ns/1ps
module lpbc_monitor #(parameter int STEP_CYCLES = 2) (
    // clock, reset, handshakes, read data, pins
    input wire logic REF_CLK, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID,
    input wire logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  LAMP_OE_N
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // register read data and reset pin state
    property p_rd_hi; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("read upper bits set");
    property p_pin_rst; $fell(RST) |-> LAMP_OE_N == 2'h3; endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("lamp pin not idle");
    // write handshake timing
    property p_b_lat;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write response late");
    property p_aw_busy; S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY; endproperty
    a_aw_busy: assert property (p_aw_busy) else $error("address ready stayed high");
    property p_w_busy; S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_WREADY; endproperty
    a_w_busy: assert property (p_w_busy) else $error("data ready stayed high");
    property p_b_busy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    a_b_busy: assert property (p_b_busy) else $error("ready during response");
    // read handshake timing
    property p_r_lat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read data late");
    property p_r_busy; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_r_busy: assert property (p_r_busy) else $error("read ready during data");
    // main scenarios
    c_wr: cover property (S_AXI_BVALID);
    c_rd: cover property (S_AXI_RVALID);
    c_lit: cover property (LAMP_OE_N != 2'h3);
endmodule : lpbc_monitor

bind lpbc_top lpbc_monitor #(.STEP_CYCLES(STEP_CYCLES)) mon_u (.REF_CLK(REF_CLK), .RST(RST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RDATA(S_AXI_RDATA),
    .LAMP_OE_N(LAMP_OE_N));

// File: tb.sv
// testbench: register access and lamp pin levels of lpbc_top
// assumes: lamp load model on the pins, short step parameter
`timescale 1ns/1ps
`include "lpbc_defines.svh"
module tb;
    logic        ref_clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0]  touch = 2'h0, br, rr, lo, loe, pin;
    logic        awr, wrdy, bv, arr, rv;
    int          n_errors = 0, n_checks = 0;

    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;

    lpbc_top #(.STEP_CYCLES(2)) dut_u (.REF_CLK(ref_clk), .RST(rst), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1),
        .TOUCH_IN(touch), .LAMP_OUT(lo), .LAMP_OE_N(loe));
    lpbc_lamp_load load_u (.lamp_out(lo), .lamp_oe_n(loe), .pin_level(pin));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // bus write, address and data together
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        int k;
        awa <= {2'b00, idx, 2'b00};
        wd  <= {24'h0, d};
        awv <= 1'b1;
        wv  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge ref_clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (bv) break;
        end
        chk("write resp", {30'h0, br}, 32'h0);
        if (k == 40) n_errors++;
        if (k == 40) report_and_stop();
    endtask : wr

    // bus read, data and response compared
    task automatic rchk(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
        int k;
        ara <= {2'b00, idx, 2'b00};
        arv <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge ref_clk);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        chk("read data", rd, ed);
        chk("read resp", {30'h0, rr}, {30'h0, er});
        if (k == 40) n_errors++;
        if (k == 40) report_and_stop();
    endtask : rchk

    // pin high cycles over a pwm period
    task automatic lit(input int g, input logic [31:0] exp);
        logic [31:0] n;
        n = 32'h0;
        repeat (8) @(posedge ref_clk);
        repeat (256) begin
            @(posedge ref_clk);
            if (pin[g] === 1'b1) n++;
        end
        chk("pin high cycles", n, exp);
    endtask : lit

    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rchk(`LPBC_IDX_POL, 32'h0, 2'h0);
        rchk(`LPBC_IDX_DRIVE, 32'h0, 2'h0);
        rchk(`LPBC_IDX_BEHAV, 32'h0, 2'h0);
        rchk(8'h50, 32'h0, 2'h2);
        wr(`LPBC_IDX_POL, 8'hFF);
        rchk(`LPBC_IDX_POL, 32'h3, 2'h0);
        wr(`LPBC_IDX_DRIVE, 8'hFF);
        rchk(`LPBC_IDX_DRIVE, 32'h3, 2'h0);
        wr(`LPBC_IDX_DRIVE, 8'h00);
        wr(`LPBC_IDX_BEHAV, 8'hFF);
        rchk(`LPBC_IDX_BEHAV, 32'hF, 2'h0);
        wr(`LPBC_IDX_BEHAV, 8'h00);
        wr(`LPBC_IDX_POL, 8'h00);
        wr(`LPBC_IDX_DRIVE, 8'h01);
        lit(0, 32'd1);
        lit(1, 32'd256);
        wr(`LPBC_IDX_DRIVE, 8'h00);
        lit(0, 32'd256);
        wr(`LPBC_IDX_POL, 8'h03);
        lit(0, 32'd0);
        wr(`LPBC_IDX_DRIVE, 8'h02);
        lit(1, 32'd255);
        wr(`LPBC_IDX_DRIVE, 8'h00);
        wr(`LPBC_IDX_POL, 8'h00);
        wr(`LPBC_IDX_LINK, 8'h02);
        touch <= 2'b10;
        lit(1, 32'd1);
        touch <= 2'b00;
        lit(1, 32'd256);
        wr(`LPBC_IDX_OTYPE, 8'h03);
        repeat (8) @(posedge ref_clk);
        chk("pin enable", {30'h0, loe}, 32'h0);
        chk("pin drive", {30'h0, lo}, 32'h3);
        wr(`LPBC_IDX_BEHAV, 8'h03);
        wr(`LPBC_IDX_DRIVE, 8'h01);
        wr(`LPBC_IDX_POL, 8'h00);
        rchk(`LPBC_IDX_STATUS, 32'h5, 2'h0);
        report_and_stop();
    end
endmodule : tb
